/* File: design/sdp_consts.vh */
// Purpose: Shared constants of the low-power SDRAM pin interface
// Assumes: Included by bare name from every design file except the bank tracker
// Notes:   Definitions only
`ifndef SDP_CONSTS_VH
`define SDP_CONSTS_VH

// ----------------------------------------------------------------
// Command codes {ras_b, cas_b, we_b} with cs_b low
// ----------------------------------------------------------------
`define SDP_CMD_MRS      3'h0
`define SDP_CMD_REF      3'h1
`define SDP_CMD_PRE      3'h2
`define SDP_CMD_ACT      3'h3
`define SDP_CMD_WR       3'h4
`define SDP_CMD_RD       3'h5
`define SDP_CMD_BST      3'h6
`define SDP_CMD_NOP      3'h7

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define SDP_MR_BL_LSB    0
`define SDP_MR_BL_MSB    2
`define SDP_MR_BT_BIT    3
`define SDP_MR_CL_LSB    4
`define SDP_MR_CL_MSB    6
`define SDP_MR_WB_BIT    9
`define SDP_AP_BIT       10
`define SDP_BL_1         3'h0
`define SDP_BL_2         3'h1
`define SDP_BL_4         3'h2
`define SDP_BL_8         3'h3
`define SDP_BL_PAGE      3'h7
`define SDP_CL_2         3'h2
`define SDP_CL_3         3'h3
`define SDP_MR_RESET     13'h0020
`define SDP_EMR_RESET    13'h0000
`define SDP_SEL_MR       2'h0
`define SDP_SEL_EMR      2'h2
`define SDP_DQM_LAT      2

// ----------------------------------------------------------------
// Power states
// ----------------------------------------------------------------
`define SDP_PS_RUN       3'h0
`define SDP_PS_PPD       3'h1
`define SDP_PS_APD       3'h2
`define SDP_PS_SUSP      3'h3
`define SDP_PS_SREF      3'h4
`define SDP_PS_DPD       3'h5

`endif

/* File: design/sdp_bank.v */
// Purpose: One bank's open-row tracker
// Assumes: Activate and close never requested together
// Notes:   Four instances give four independent banks
`timescale 1ns/1ps

module sdp_bank (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        act,
    input  wire        close,
    input  wire [12:0] row_in,
    output reg         open_q,
    output reg  [12:0] row_q
);

    always @(posedge clk) begin
        if (!rst_b) begin
            open_q <= 1'b0;
            row_q  <= 13'h0000;
        end else if (close) begin
            open_q <= 1'b0;
        end else if (act) begin
            open_q <= 1'b1;
            row_q  <= row_in;
        end
    end

endmodule // sdp_bank

/* File: design/sdp_burst_col.v */
// Purpose: Column of one burst element
// Assumes: Full page only with sequential order
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "sdp_consts.vh"

module sdp_burst_col (
    input  wire [8:0] start,
    input  wire [8:0] idx,
    input  wire [2:0] bl_code,
    input  wire       interleave,
    output reg  [8:0] col
);

    reg [8:0] wrap_mask;
    reg [8:0] sum;

    always @* begin
        sum = start + idx;
        case (bl_code)
            `SDP_BL_1: wrap_mask = 9'h000;
            `SDP_BL_2: wrap_mask = 9'h001;
            `SDP_BL_4: wrap_mask = 9'h003;
            `SDP_BL_8: wrap_mask = 9'h007;
            default:   wrap_mask = 9'h1ff;
        endcase
        // Wraps inside the aligned block
        if (interleave && bl_code != `SDP_BL_PAGE)
            col = (start & ~wrap_mask) | ((start ^ idx) & wrap_mask);
        else
            col = (start & ~wrap_mask) | (sum & wrap_mask);
    end

endmodule // sdp_burst_col

/* File: design/sdp_pin_iface.v */
// Purpose: Device side of a four-bank 16-bit low-power SDRAM pin interface
// Assumes: Controller clock is clk; all pins synchronous to it
// Notes:   Memory depth set by MEM_AW; self-refresh exit seen on a clock edge
`timescale 1ns/1ps
`include "sdp_consts.vh"

module sdp_pin_iface #(
    parameter MEM_AW = 24
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        cke,
    input  wire        cs_b,
    input  wire        ras_b,
    input  wire        cas_b,
    input  wire        we_b,
    input  wire [1:0]  bank_select,
    input  wire [12:0] address_bus,
    input  wire        low_byte_mask,
    input  wire        high_byte_mask,
    input  wire [15:0] data_bus_i,
    output wire [15:0] data_bus_o,
    output wire [1:0]  data_bus_oe,
    output wire [2:0]  power_state,
    output wire [3:0]  bank_open,
    output wire [12:0] mode_word,
    output wire [12:0] ext_mode_word
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg  [7:0]  mem_lo [0:(1<<MEM_AW)-1];
    reg  [7:0]  mem_hi [0:(1<<MEM_AW)-1];

    // ------------------------------------------------------------
    // Power state codes
    // ------------------------------------------------------------
    localparam [2:0] PS_RUN  = `SDP_PS_RUN;
    localparam [2:0] PS_PPD  = `SDP_PS_PPD;
    localparam [2:0] PS_APD  = `SDP_PS_APD;
    localparam [2:0] PS_SUSP = `SDP_PS_SUSP;
    localparam [2:0] PS_SREF = `SDP_PS_SREF;
    localparam [2:0] PS_DPD  = `SDP_PS_DPD;

    // ------------------------------------------------------------
    // Registers and wires
    // ------------------------------------------------------------
    reg         cke_q;
    reg  [2:0]  pwr_q;
    reg  [2:0]  pwr_d;
    reg  [12:0] mode_q;
    reg  [12:0] ext_q;
    reg         bst_act_q;
    reg         bst_wr_q;
    reg         bst_ap_q;
    reg  [1:0]  bst_bank_q;
    reg  [12:0] bst_row_q;
    reg  [8:0]  bst_start_q;
    reg  [8:0]  bst_cnt_q;
    reg  [1:0]  msk1_q;
    reg  [1:0]  msk2_q;
    reg         p1_v_q;
    reg  [15:0] p1_d_q;
    reg         out_v_q;
    reg  [15:0] out_d_q;
    wire [12:0] row_w [0:3];
    wire [3:0]  open_w;
    wire [3:0]  act_w;
    wire [3:0]  close_w;
    wire [8:0]  bst_col;
    wire        en;
    wire [2:0]  cmd;
    wire        cmd_ok;
    wire        is_mrs;
    wire        is_act;
    wire        is_pre;
    wire        is_rd;
    wire        is_wr;
    wire        is_bst;
    wire        new_acc;
    wire        rows_left;
    wire        busy;
    wire        lat3;
    wire        single_wr;
    wire        page;
    wire [8:0]  last_idx;
    wire        bst_step;
    wire        bst_end;
    wire        rd_fire;
    wire        wr_now;
    wire [MEM_AW-1:0] wr_addr;
    wire [MEM_AW-1:0] rd_addr;
    wire [23:0] wr_full;
    wire [23:0] rd_full;
    wire [15:0] rd_data;
    reg  [8:0]  len_m1;

    // ------------------------------------------------------------
    // Clock enable and command decode
    // ------------------------------------------------------------
    // Sampled enable gates the next edge, like a stopped internal clock
    assign en     = cke_q && (pwr_q == `SDP_PS_RUN);
    assign cmd    = {ras_b, cas_b, we_b};
    assign cmd_ok = en && !cs_b;
    assign is_mrs = cmd_ok && cmd == `SDP_CMD_MRS;
    assign is_act = cmd_ok && cmd == `SDP_CMD_ACT;
    assign is_pre = cmd_ok && cmd == `SDP_CMD_PRE;
    assign is_bst = cmd_ok && cmd == `SDP_CMD_BST;
    // Access to a closed bank is dropped
    assign is_rd  = cmd_ok && cmd == `SDP_CMD_RD && open_w[bank_select];
    assign is_wr  = cmd_ok && cmd == `SDP_CMD_WR && open_w[bank_select];
    assign new_acc = is_rd || is_wr;

    always @(posedge clk) begin
        if (!rst_b)
            cke_q <= 1'b1;
        else
            cke_q <= cke;
    end

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            mode_q <= `SDP_MR_RESET;
            ext_q  <= `SDP_EMR_RESET;
        end else if (is_mrs) begin
            if (bank_select == `SDP_SEL_MR)
                mode_q <= address_bus;
            else if (bank_select == `SDP_SEL_EMR)
                ext_q <= address_bus;
        end
    end

    assign lat3      = mode_q[`SDP_MR_CL_MSB:`SDP_MR_CL_LSB] == `SDP_CL_3;
    assign single_wr = mode_q[`SDP_MR_WB_BIT];
    assign page      = mode_q[`SDP_MR_BL_MSB:`SDP_MR_BL_LSB] == `SDP_BL_PAGE;

    always @* begin
        case (mode_q[`SDP_MR_BL_MSB:`SDP_MR_BL_LSB])
            `SDP_BL_1: len_m1 = 9'h000;
            `SDP_BL_2: len_m1 = 9'h001;
            `SDP_BL_4: len_m1 = 9'h003;
            `SDP_BL_8: len_m1 = 9'h007;
            default:   len_m1 = 9'h1ff;
        endcase
    end

    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    // Chosen from the rows open before this edge and not closed at it
    assign rows_left = |(open_w & ~close_w);
    assign busy      = bst_act_q || out_v_q || p1_v_q || new_acc;

    always @* begin
        pwr_d = pwr_q;
        case (pwr_q)
            PS_RUN: begin
                if (cke_q && !cke) begin
                    if (!cs_b && cmd == `SDP_CMD_REF)
                        pwr_d = PS_SREF;
                    else if (busy)
                        pwr_d = PS_SUSP;
                    else if (rows_left)
                        pwr_d = PS_APD;
                    else if (!cs_b && cmd == `SDP_CMD_BST)
                        pwr_d = PS_DPD;
                    else
                        pwr_d = PS_PPD;
                end
            end
            PS_PPD, PS_APD, PS_SUSP, PS_SREF, PS_DPD: begin
                // Self-refresh exit needs no other input than the enable
                if (cke)
                    pwr_d = PS_RUN;
            end
            default: pwr_d = PS_RUN;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b)
            pwr_q <= PS_RUN;
        else
            pwr_q <= pwr_d;
    end

    // ------------------------------------------------------------
    // Banks
    // ------------------------------------------------------------
    // Deep power-down closes every bank; the memory array keeps its data
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_bank
            assign act_w[b]   = is_act && bank_select == b;
            assign close_w[b] = (is_pre && (address_bus[`SDP_AP_BIT] || bank_select == b))
                              || (bst_end && bst_ap_q && bst_bank_q == b)
                              || (is_wr && address_bus[`SDP_AP_BIT] && bank_select == b
                                  && (single_wr || len_m1 == 9'h000))
                              || (pwr_q == `SDP_PS_DPD);
            sdp_bank u_bank (
                .clk    (clk),
                .rst_b  (rst_b),
                .act    (act_w[b]),
                .close  (close_w[b]),
                .row_in (address_bus),
                .open_q (open_w[b]),
                .row_q  (row_w[b])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Burst engine
    // ------------------------------------------------------------
    sdp_burst_col u_col (
        .start      (bst_start_q),
        .idx        (bst_cnt_q),
        .bl_code    (mode_q[`SDP_MR_BL_MSB:`SDP_MR_BL_LSB]),
        .interleave (mode_q[`SDP_MR_BT_BIT]),
        .col        (bst_col)
    );

    assign last_idx = (bst_wr_q && single_wr) ? 9'h000 : len_m1;
    assign bst_step = bst_act_q && en && !new_acc && !is_bst;
    // Full page never ends by itself
    assign bst_end  = bst_step && !(page && !(bst_wr_q && single_wr)) && bst_cnt_q == last_idx;
    assign rd_fire  = bst_step && !bst_wr_q;

    always @(posedge clk) begin
        if (!rst_b) begin
            bst_act_q   <= 1'b0;
            bst_wr_q    <= 1'b0;
            bst_ap_q    <= 1'b0;
            bst_bank_q  <= 2'h0;
            bst_row_q   <= 13'h0000;
            bst_start_q <= 9'h000;
            bst_cnt_q   <= 9'h000;
        end else if (new_acc) begin
            bst_wr_q    <= is_wr;
            bst_ap_q    <= address_bus[`SDP_AP_BIT];
            bst_bank_q  <= bank_select;
            bst_row_q   <= row_w[bank_select];
            bst_start_q <= address_bus[8:0];
            // Write element 0 goes with the command itself
            bst_cnt_q   <= is_wr ? 9'h001 : 9'h000;
            bst_act_q   <= is_rd || !(single_wr || len_m1 == 9'h000);
        end else if (is_bst || (pwr_q == `SDP_PS_DPD)) begin
            bst_act_q <= 1'b0;
        end else if (bst_step) begin
            if (bst_end)
                bst_act_q <= 1'b0;
            else
                bst_cnt_q <= bst_cnt_q + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // Memory write and read
    // ------------------------------------------------------------
    assign wr_now  = is_wr || (bst_step && bst_wr_q);
    assign wr_full = is_wr ? {bank_select, row_w[bank_select], address_bus[8:0]}
                           : {bst_bank_q, bst_row_q, bst_col};
    assign rd_full = {bst_bank_q, bst_row_q, bst_col};
    assign wr_addr = wr_full[MEM_AW-1:0];
    assign rd_addr = rd_full[MEM_AW-1:0];
    assign rd_data = {mem_hi[rd_addr], mem_lo[rd_addr]};

    always @(posedge clk) begin
        if (wr_now && !low_byte_mask)
            mem_lo[wr_addr] <= data_bus_i[7:0];
        if (wr_now && !high_byte_mask)
            mem_hi[wr_addr] <= data_bus_i[15:8];
    end

    // ------------------------------------------------------------
    // Read pipeline and output mask
    // ------------------------------------------------------------
    // Frozen while the clock enable is low, so suspend holds the data
    always @(posedge clk) begin
        if (!rst_b) begin
            p1_v_q  <= 1'b0;
            p1_d_q  <= 16'h0000;
            out_v_q <= 1'b0;
            out_d_q <= 16'h0000;
            msk1_q  <= 2'h3;
            msk2_q  <= 2'h3;
        end else if (en) begin
            p1_v_q  <= rd_fire;
            p1_d_q  <= rd_data;
            out_v_q <= lat3 ? p1_v_q : rd_fire;
            out_d_q <= lat3 ? p1_d_q : rd_data;
            msk1_q  <= {high_byte_mask, low_byte_mask};
            msk2_q  <= msk1_q;
        end
    end

    // Drivers off whenever the internal clock is stopped
    assign data_bus_o     = out_d_q;
    assign data_bus_oe[0] = out_v_q && !msk2_q[0] && en;
    assign data_bus_oe[1] = out_v_q && !msk2_q[1] && en;

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    assign power_state   = pwr_q;
    assign bank_open     = open_w;
    assign mode_word     = mode_q;
    assign ext_mode_word = ext_q;

endmodule // sdp_pin_iface

/* File: tb/sdp_pin_checker.sv */
// Purpose: Port-level checks of the SDRAM pin interface
// Assumes: Bound to sdp_pin_iface; one clock domain
// Notes:   Command take is the run-state gating plus cke high at the previous edge; live also needs cke high at the same edge
`timescale 1ns/1ps
`include "sdp_consts.vh"

module sdp_pin_checker (
    input wire        clk,
    input wire        rst_b,
    input wire        cke,
    input wire        cs_b,
    input wire        ras_b,
    input wire        cas_b,
    input wire        we_b,
    input wire [1:0]  bank_select,
    input wire [12:0] address_bus,
    input wire        low_byte_mask,
    input wire        high_byte_mask,
    input wire [1:0]  data_bus_oe,
    input wire [2:0]  power_state,
    input wire [3:0]  bank_open,
    input wire [12:0] mode_word,
    input wire [12:0] ext_mode_word
);
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    reg        cke_q;
    wire [2:0] cmd  = {ras_b, cas_b, we_b};
    wire       live = (power_state == `SDP_PS_RUN) && cke_q && cke && !cs_b;

    always @(posedge clk) begin
        cke_q <= cke;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    property p_act; live && cmd == `SDP_CMD_ACT |=> bank_open[$past(bank_select)]; endproperty
    a_act: assert property (p_act)
        else $error("activate did not open its bank");
    property p_pre_all; live && cmd == `SDP_CMD_PRE && address_bus[10] |=> bank_open == 4'h0; endproperty
    a_pre_all: assert property (p_pre_all)
        else $error("precharge all left a bank open");
    property p_mr; live && cmd == `SDP_CMD_MRS && bank_select == `SDP_SEL_MR |=> mode_word == $past(address_bus); endproperty
    a_mr: assert property (p_mr)
        else $error("mode word not loaded from address");
    property p_emr; live && cmd == `SDP_CMD_MRS && bank_select == `SDP_SEL_EMR |=> ext_mode_word == $past(address_bus);
    endproperty
    a_emr: assert property (p_emr)
        else $error("extended mode word not loaded");
    property p_mr_bad; live && cmd == `SDP_CMD_MRS && bank_select[0] |=> $stable(mode_word) && $stable(ext_mode_word);
    endproperty
    a_mr_bad: assert property (p_mr_bad)
        else $error("odd bank select changed a mode word");
    property p_cs; power_state == `SDP_PS_RUN && cs_b && bank_open == 4'h0 |=> bank_open == 4'h0; endproperty
    a_cs: assert property (p_cs)
        else $error("deselected command opened a bank");
    property p_apd; power_state == `SDP_PS_APD |-> bank_open != 4'h0; endproperty
    a_apd: assert property (p_apd)
        else $error("active power-down with all banks idle");
    property p_hold; power_state != `SDP_PS_RUN |=> $stable(bank_open) && $stable(mode_word); endproperty
    a_hold: assert property (p_hold)
        else $error("input acted on while powered down");
    property p_off; power_state != `SDP_PS_RUN |-> data_bus_oe == 2'h0; endproperty
    a_off: assert property (p_off)
        else $error("data driven while clock disabled");
    property p_float; $past(high_byte_mask, 2) |-> !data_bus_oe[1]; endproperty
    a_float: assert property (p_float)
        else $error("high byte driven two clocks after mask");
    property p_lat;
        live && cmd == `SDP_CMD_RD && bank_open[bank_select] && mode_word[6:4] == `SDP_CL_2 && !low_byte_mask
        |=> (cke && (cs_b || cmd == `SDP_CMD_NOP)) |=> data_bus_oe[0];
    endproperty
    a_lat: assert property (p_lat)
        else $error("read data missing at latency two");
endmodule // sdp_pin_checker

/* File: tb/sdp_ctrl_model.sv */
// Purpose: Controller model driving the SDRAM pins
// Assumes: Bench sets cke_nx and mask before each send
// Notes:   Released data lines alternate between the last write data and its inverse
`timescale 1ns/1ps
`include "sdp_consts.vh"

module sdp_ctrl_model (
    input  wire        clk,
    output reg         cke,
    output reg         cs_b,
    output reg         ras_b,
    output reg         cas_b,
    output reg         we_b,
    output reg  [1:0]  bank_select,
    output reg  [12:0] address_bus,
    output reg         low_byte_mask,
    output reg         high_byte_mask,
    output reg  [15:0] data_bus_i
);
    // ------------------------------------------------
    // Pin driver
    // ------------------------------------------------
    reg       cke_nx;
    reg [1:0] mask;

    initial begin
        {cke, cs_b, ras_b, cas_b, we_b, bank_select, address_bus} = {5'h1f, 15'h0};
        {low_byte_mask, high_byte_mask, data_bus_i} = 18'h0;
        cke_nx = 1'b1;
        mask = 2'h0;
    end

    task send(input sel_b, input [2:0] code, input [1:0] ba, input [12:0] addr, input [15:0] wd);
        begin
            @(posedge clk);
            #2;
            cke = cke_nx;
            {cs_b, ras_b, cas_b, we_b} = {sel_b, code};
            bank_select = ba;
            address_bus = addr;
            {high_byte_mask, low_byte_mask} = mask;
            // Inverted when not writing, so every second non-write send shows the last write value again
            data_bus_i = (code == `SDP_CMD_WR) ? wd : ~data_bus_i;
        end
    endtask

    task start_up;
        begin
            send(1'b0, `SDP_CMD_PRE, 2'h0, 13'h0400, 16'h0);
            // Whole run fits inside one refresh interval
            repeat (2) begin
                send(1'b0, `SDP_CMD_REF, 2'h0, 13'h0, 16'h0);
                repeat (4) send(1'b1, `SDP_CMD_NOP, 2'h0, 13'h0, 16'h0);
            end
        end
    endtask
endmodule // sdp_ctrl_model

/* File: tb/sdp_pin_iface_test.sv */
// Purpose: Self-checking bench of the SDRAM pin interface
// Assumes: Controller model drives every pin except clk and rst_b
// Notes:   MEM_AW reduced; one bank and row carry the data
`timescale 1ns/1ps
`include "sdp_consts.vh"

module sdp_pin_iface_test;
    reg         clk;
    reg         rst_b;
    wire        cke, cs_b, ras_b, cas_b, we_b, low_byte_mask, high_byte_mask;
    wire [1:0]  bank_select, data_bus_oe;
    wire [12:0] address_bus, mode_word, ext_mode_word;
    wire [15:0] data_bus_i, data_bus_o;
    wire [2:0]  power_state;
    wire [3:0]  bank_open;
    reg  [15:0] mdl [0:15];
    reg  [12:0] v, ev;
    reg  [15:0] d;
    integer     n_mismatch, n_tests, i, j, k, lat, bt, bl, c, s;

    sdp_pin_iface #(.MEM_AW(12)) sdp_pin_iface_inst (
        .clk(clk), .rst_b(rst_b), .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
        .bank_select(bank_select), .address_bus(address_bus), .low_byte_mask(low_byte_mask),
        .high_byte_mask(high_byte_mask), .data_bus_i(data_bus_i), .data_bus_o(data_bus_o),
        .data_bus_oe(data_bus_oe), .power_state(power_state), .bank_open(bank_open),
        .mode_word(mode_word), .ext_mode_word(ext_mode_word));
    sdp_ctrl_model sdp_ctrl_model_inst (
        .clk(clk), .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
        .bank_select(bank_select), .address_bus(address_bus), .low_byte_mask(low_byte_mask),
        .high_byte_mask(high_byte_mask), .data_bus_i(data_bus_i));

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task check(input [95:0] what, input [15:0] exp, input [15:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task cmd(input [2:0] code, input [1:0] ba, input [12:0] a, input [15:0] wd);
        sdp_ctrl_model_inst.send(1'b0, code, ba, a, wd);
    endtask
    task nop;
        cmd(`SDP_CMD_NOP, 2'h0, 13'h0, 16'h0);
    endtask
    task close_out;
        begin
            $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Wrap inside the aligned block of the burst
    function integer col_at(input integer st, input integer len, input integer il, input integer x);
        col_at = (st & ~(len - 1)) | ((il ? (st ^ x) : (st + x)) & (len - 1));
    endfunction

    // ------------------------------------------------
    // Stimulus
    // ------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #125000;
        n_mismatch = n_mismatch + 1;
        close_out;
    end
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        rst_b = 1'b0;
        d = $urandom(55);
        repeat (3) @(posedge clk);
        #2 rst_b = 1'b1;
        check("mode rst", `SDP_MR_RESET, mode_word);
        check("state rst", 16'h0, {ext_mode_word, power_state});
        sdp_ctrl_model_inst.start_up;
        cmd(`SDP_CMD_MRS, `SDP_SEL_MR, 13'h0203, 16'h0);
        ev = $urandom;
        cmd(`SDP_CMD_MRS, `SDP_SEL_EMR, ev, 16'h0);
        cmd(`SDP_CMD_MRS, 2'h1, ~ev, 16'h0);
        nop;
        check("mode", 13'h0203, mode_word);
        check("ext mode", ev, ext_mode_word);
        for (i = 0; i < 4; i = i + 1) cmd(`SDP_CMD_ACT, i[1:0], $urandom, 16'h0);
        nop;
        check("open", 4'hf, bank_open);
        cmd(`SDP_CMD_PRE, 2'h2, 13'h0, 16'h0);
        nop;
        check("pre one", 4'hb, bank_open);
        cmd(`SDP_CMD_PRE, 2'h1, 13'h0400, 16'h0);
        sdp_ctrl_model_inst.send(1'b1, `SDP_CMD_ACT, 2'h0, 13'h0a5, 16'h0);
        nop;
        check("pre all", 4'h0, bank_open);
        cmd(`SDP_CMD_ACT, 2'h0, 13'h0a5, 16'h0);
        for (c = 0; c < 16; c = c + 1) begin
            mdl[c] = $urandom;
            cmd(`SDP_CMD_WR, 2'h0, c[12:0], mdl[c]);
        end
        sdp_ctrl_model_inst.mask = 2'h1;
        d = $urandom;
        cmd(`SDP_CMD_WR, 2'h0, 13'h3, d);
        mdl[3][15:8] = d[15:8];
        sdp_ctrl_model_inst.mask = 2'h0;
        sdp_ctrl_model_inst.send(1'b1, `SDP_CMD_WR, 2'h0, 13'h5, ~mdl[5]);
        for (lat = 2; lat <= 3; lat = lat + 1)
            for (bt = 0; bt < 2; bt = bt + 1)
                for (k = 0; k < 4; k = k + 1) begin
                    bl = 1 << k;
                    s = bt * 8 + $urandom % 8;
                    v = {6'h0, lat[2:0], bt[0], k[2:0]};
                    cmd(`SDP_CMD_PRE, 2'h0, 13'h0400, 16'h0);
                    cmd(`SDP_CMD_MRS, `SDP_SEL_MR, v, 16'h0);
                    cmd(`SDP_CMD_ACT, 2'h0, 13'h0a5, 16'h0);
                    cmd(`SDP_CMD_RD, 2'h0, s[12:0], 16'h0);
                    for (i = 1; i <= lat + bl; i = i + 1) begin
                        sdp_ctrl_model_inst.mask = (i == lat - 1 && bl > 1) ? 2'h2 : 2'h0;
                        nop;
                        if (i == lat - 1 || i == lat + bl) check("oe idle", 2'h0, data_bus_oe);
                        if (i >= lat && i < lat + bl) begin
                            c = col_at(s, bl, bt, i - lat);
                            check("oe", (i == lat + 1 && bl > 1) ? 2'h1 : 2'h3, data_bus_oe);
                            check("rd low", mdl[c][7:0], data_bus_o[7:0]);
                            if (i != lat + 1 || bl == 1) check("rd high", mdl[c][15:8], data_bus_o[15:8]);
                        end
                    end
                end
        cmd(`SDP_CMD_RD, 2'h0, 13'h0402, 16'h0);
        repeat (14) nop;
        check("auto pre", 4'h0, bank_open);
        for (j = 0; j < 5; j = j + 1) begin
            if (j == 3) cmd(`SDP_CMD_ACT, 2'h1, 13'h0a5, 16'h0);
            if (j == 4) cmd(`SDP_CMD_RD, 2'h1, 13'h0, 16'h0);
            sdp_ctrl_model_inst.cke_nx = 1'b0;
            cmd(j == 1 ? `SDP_CMD_REF : j == 2 ? `SDP_CMD_BST : `SDP_CMD_NOP, 2'h0, 13'h0, 16'h0);
            cmd(`SDP_CMD_MRS, `SDP_SEL_MR, 13'h1fff, 16'h0);
            check("pwr", j == 0 ? `SDP_PS_PPD : j == 1 ? `SDP_PS_SREF : j == 2 ? `SDP_PS_DPD :
                j == 3 ? `SDP_PS_APD : `SDP_PS_SUSP, power_state);
            sdp_ctrl_model_inst.cke_nx = 1'b1;
            nop;
            nop;
            check("pwr exit", `SDP_PS_RUN, power_state);
            check("pd mode", v, mode_word);
            check("pd open", j >= 3 ? 4'h2 : 4'h0, bank_open);
        end
        close_out;
    end
endmodule // sdp_pin_iface_test

bind sdp_pin_iface sdp_pin_checker sdp_pin_checker_inst (
    .clk(clk), .rst_b(rst_b), .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
    .bank_select(bank_select), .address_bus(address_bus), .low_byte_mask(low_byte_mask),
    .high_byte_mask(high_byte_mask), .data_bus_oe(data_bus_oe), .power_state(power_state),
    .bank_open(bank_open), .mode_word(mode_word), .ext_mode_word(ext_mode_word));
